/* File: rtl/pwp_cfg.svh */
`ifndef PWP_CFG_SVH
`define PWP_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PWP_PW_FIRST 8'h39
`define PWP_PW_LAST 8'h3C
`define PWP_EE_ADDR 8'h3D
`define PWP_EE_DATA 8'h3E
`define PWP_EE_CMD 8'h3F
`define PWP_MIR_FIRST 8'hC0
`define PWP_MIR_LAST 8'hCA
`define PWP_REF_FIRST 8'hC6
`define PWP_REF_LAST 8'hC9
`define PWP_EN_ADDR 8'hCA

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define PWP_REF_IDX 6
`define PWP_EN_IDX 10
`define PWP_EN_ON 8'hFF
`define PWP_CMD_UPDATE 8'h11
`define PWP_CMD_READ 8'h22
`define PWP_PW_RESET 32'h00000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PWP_CLK_HZ 10000000
`define PWP_PREFR_MS 66
`define PWP_PREFR_CYC (`PWP_PREFR_MS * (`PWP_CLK_HZ / 1000))

`endif

/* File: rtl/pwp_core.sv */
`timescale 1ns/10ps

`include "pwp_cfg.svh"

module pwp_core #(
	parameter int REFRESH_CYCLES = `PWP_PREFR_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire pwp_pkg::pwp_req_t acc_req,
	input wire logic [10:0][7:0] nv_image,
	output logic wr_grant,
	output logic ready,
	output logic locked,
	output logic [7:0] acc_rdata,
	output logic acc_rvalid,
	output logic nv_store,
	output logic [10:0][7:0] nv_store_data
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic in_span(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [3:0] sub_idx(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] diff;
		diff = a - base;
		sub_idx = diff[3:0];
	endfunction

	pwp_pkg::pwp_regs_t q, d;
	logic prot_on;
	logic pw_match;
	logic unlocked;
	logic pw_hit;
	logic mir_hit;
	logic [31:0] ref_pw;
	logic [3:0] idx;
	logic [3:0] ee_idx;

	// ----------------------------------------------------------------
	// Protection decode
	// ----------------------------------------------------------------
	assign ref_pw = {q.mir[`PWP_REF_IDX + 3], q.mir[`PWP_REF_IDX + 2],
		q.mir[`PWP_REF_IDX + 1], q.mir[`PWP_REF_IDX]};
	assign prot_on = q.mir[`PWP_EN_IDX] == `PWP_EN_ON;
	assign pw_match = q.pw == ref_pw;
	assign unlocked = !prot_on || pw_match;
	assign pw_hit = in_span(acc_req.addr, `PWP_PW_FIRST, `PWP_PW_LAST);
	assign mir_hit = in_span(acc_req.addr, `PWP_MIR_FIRST, `PWP_MIR_LAST);
	assign ready = q.st == pwp_pkg::PWP_ST_RUN;
	assign locked = !unlocked;
	// Entry bytes stay open so the host can always unlock or relock
	assign wr_grant = ready && acc_req.wr && (unlocked || pw_hit);
	assign acc_rdata = q.rdata;
	assign acc_rvalid = q.rvalid;
	assign nv_store = q.nv_store;
	assign nv_store_data = q.mir;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.nv_store = 1'b0;
		d.rvalid = 1'b0;
		idx = 4'h0;
		ee_idx = sub_idx(q.ee_addr, `PWP_MIR_FIRST);
		unique case (q.st)
			pwp_pkg::PWP_ST_BOOT: begin
				d.cnt = q.cnt + 20'h00001;
				if (q.cnt == 20'(REFRESH_CYCLES - 1)) begin
					d.pw = `PWP_PW_RESET;
					d.mir = nv_image;
					d.st = pwp_pkg::PWP_ST_RUN;
				end
			end
			pwp_pkg::PWP_ST_RUN: begin
				if (wr_grant) begin
					if (pw_hit) begin
						idx = sub_idx(acc_req.addr, `PWP_PW_FIRST);
						d.pw[idx[1:0]] = acc_req.wdata;
					end else if (mir_hit) begin
						idx = sub_idx(acc_req.addr, `PWP_MIR_FIRST);
						d.mir[idx] = acc_req.wdata;
					end else if (acc_req.addr == `PWP_EE_ADDR) begin
						d.ee_addr = acc_req.wdata;
					end else if (acc_req.addr == `PWP_EE_DATA) begin
						d.ee_data = acc_req.wdata;
					end else if (acc_req.addr == `PWP_EE_CMD) begin
						if (acc_req.wdata == `PWP_CMD_UPDATE) begin
							d.nv_store = 1'b1;
						end else if (acc_req.wdata == `PWP_CMD_READ) begin
							if (in_span(q.ee_addr, `PWP_MIR_FIRST, `PWP_MIR_LAST)) begin
								d.ee_data = nv_image[ee_idx];
							end else begin
								d.ee_data = 8'h00;
							end
						end
					end
				end
				// Reads are served in every protection state
				if (acc_req.rd) begin
					d.rvalid = 1'b1;
					d.rdata = 8'h00;
					if (pw_hit) begin
						idx = sub_idx(acc_req.addr, `PWP_PW_FIRST);
						d.rdata = q.pw[idx[1:0]];
					end else if (mir_hit &&
						!in_span(acc_req.addr, `PWP_REF_FIRST, `PWP_REF_LAST)) begin
						idx = sub_idx(acc_req.addr, `PWP_MIR_FIRST);
						d.rdata = q.mir[idx];
					end else if (acc_req.addr == `PWP_EE_ADDR) begin
						d.rdata = q.ee_addr;
					end else if (acc_req.addr == `PWP_EE_DATA) begin
						d.rdata = q.ee_data;
					end
				end
			end
			default: begin
				d.st = pwp_pkg::PWP_ST_BOOT;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{st: pwp_pkg::PWP_ST_BOOT, cnt: 20'h00000, pw: 32'h00000000,
				mir: 88'h0, ee_addr: 8'h00, ee_data: 8'h00, nv_store: 1'b0,
				rdata: 8'h00, rvalid: 1'b0};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	boot_load_a: assert property ($rose(ready) |-> q.pw == 32'h00000000 &&
		q.mir == $past(nv_image))
		else $error("mirrors not loaded at power-up refresh");

	prot_off_free_a: assert property (ready && acc_req.wr &&
		q.mir[`PWP_EN_IDX] != 8'hFF |-> wr_grant)
		else $error("write refused with protection off");

	mismatch_refuse_a: assert property (acc_req.wr && prot_on && q.pw != ref_pw &&
		!pw_hit |-> !wr_grant)
		else $error("protected write passed while locked");

	read_served_a: assert property (ready && acc_req.rd |=> acc_rvalid)
		else $error("read not answered");

	unlock_hold_a: assert property (ready && unlocked &&
		!(acc_req.wr && (pw_hit || mir_hit)) |=> unlocked)
		else $error("device relocked without entry write");

	entry_map_a: assert property (wr_grant && acc_req.addr == 8'h39 |=>
		q.pw[0] == $past(acc_req.wdata))
		else $error("entry byte 39h not stored");

	store_cmd_a: assert property (wr_grant && acc_req.addr == 8'h3F &&
		acc_req.wdata == 8'h11 |=> nv_store && nv_store_data == $past(q.mir) ##1 !nv_store)
		else $error("update command did not pulse store");

	ee_read_a: assert property (wr_grant && acc_req.addr == 8'h3F &&
		acc_req.wdata == 8'h22 && q.ee_addr == 8'hC6 |=> q.ee_data == $past(nv_image[6]))
		else $error("stored reference byte not read");

	mirror_hidden_a: assert property (ready && acc_req.rd && acc_req.addr >= 8'hC6 &&
		acc_req.addr <= 8'hC9 |=> acc_rdata == 8'h00)
		else $error("reference mirror leaked on read");

	zero_ref_a: assert property ($rose(ready) && ref_pw == 32'h00000000 |->
		!locked)
		else $error("zero reference left device locked");

	entry_open_a: assert property (ready && acc_req.wr && pw_hit |-> wr_grant)
		else $error("entry write refused");

	locked_keep_a: assert property (locked && acc_req.wr && acc_req.addr == 8'hC0 |=>
		q.mir[0] == $past(q.mir[0]))
		else $error("locked write changed a mirror byte");

endmodule

/* File: rtl/pwp_pkg.sv */
package pwp_pkg;

	typedef enum logic [1:0] {
		PWP_ST_BOOT = 2'b01,
		PWP_ST_RUN = 2'b10
	} pwp_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pwp_req_t;

	typedef struct packed {
		pwp_state_t st;
		logic [19:0] cnt;
		logic [3:0][7:0] pw;
		logic [10:0][7:0] mir;
		logic [7:0] ee_addr;
		logic [7:0] ee_data;
		logic nv_store;
		logic [7:0] rdata;
		logic rvalid;
	} pwp_regs_t;

endpackage

/* File: verif/pwp_nv_model.sv */
`timescale 1ns/10ps

// Nonvolatile configuration store on the far side of the block
module pwp_nv_model (
	input wire logic ref_clk,
	input wire logic load,
	input wire logic [10:0][7:0] preset,
	input wire logic nv_store,
	input wire logic [10:0][7:0] nv_store_data,
	output logic [10:0][7:0] nv_image
);
	always_ff @(posedge ref_clk) begin
		if (load) begin
			nv_image <= preset;
		end else if (nv_store) begin
			nv_image <= nv_store_data;
		end
	end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps

module testbench;
	logic ref_clk;
	logic resetn;
	pwp_pkg::pwp_req_t req;
	logic [10:0][7:0] img;
	logic [10:0][7:0] pre;
	logic [10:0][7:0] sd;
	logic ld, gnt, rdy, lck, rv, st;
	logic [7:0] rdat;
	int failures;
	int samples_checked;

	pwp_core #(.REFRESH_CYCLES(10)) pwp_core_inst (.ref_clk(ref_clk), .resetn(resetn),
		.acc_req(req), .nv_image(img), .wr_grant(gnt), .ready(rdy), .locked(lck),
		.acc_rdata(rdat), .acc_rvalid(rv), .nv_store(st), .nv_store_data(sd));
	pwp_nv_model pwp_nv_model_inst (.ref_clk(ref_clk), .load(ld), .preset(pre),
		.nv_store(st), .nv_store_data(sd), .nv_image(img));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic stop_test();
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic g);
		@(posedge ref_clk) req <= {1'b1, 1'b0, a, v};
		@(negedge ref_clk) chk(32'(gnt), 32'(g), "write grant");
		@(posedge ref_clk) req <= '0;
		// Return on the falling edge so callers see the settled result of the write
		@(negedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk) req <= '0;
		@(negedge ref_clk) chk({31'h0, rv}, 32'h1, "read valid");
		chk(32'(rdat), 32'(e), "read data");
	endtask

	task automatic pwd(input logic [31:0] p);
		for (int i = 0; i < 4; i++) wr(8'h39 + 8'(i), p[8*i +: 8], 1'b1);
	endtask

	task automatic refw(input logic [31:0] p);
		for (int i = 0; i < 4; i++) wr(8'hC6 + 8'(i), p[8*i +: 8], 1'b1);
	endtask

	task automatic boot();
		@(posedge ref_clk) resetn <= 1'b0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		ld <= 1'b0;
		for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge ref_clk);
		chk(32'(rdy), 32'h1, "not ready");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_boot();
		boot();
		chk(32'(lck), 32'h1, "not locked after boot");
		rd(8'h39, 8'h00);
		rd(8'hC6, 8'h00);
		rd(8'hCA, 8'hFF);
		rd(8'hC0, 8'h5A);
	endtask

	task automatic t_locked();
		wr(8'hC0, 8'hA5, 1'b0);
		rd(8'hC0, 8'h5A);
		wr(8'h3D, 8'hC7, 1'b0);
		wr(8'h3F, 8'h22, 1'b0);
		rd(8'h3E, 8'h00);
		wr(8'h39, 8'h00, 1'b1);
	endtask

	task automatic t_unlock();
		pwd(32'h11223344);
		chk(32'(lck), 32'h0, "still locked");
		wr(8'hC0, 8'hA5, 1'b1);
		rd(8'hC0, 8'hA5);
		wr(8'h3D, 8'hC7, 1'b1);
		wr(8'h3F, 8'h22, 1'b1);
		rd(8'h3E, 8'h33);
		rd(8'hC7, 8'h00);
	endtask

	task automatic t_update();
		wr(8'h3F, 8'h11, 1'b1);
		chk(32'(st), 32'h1, "no store pulse");
		@(negedge ref_clk) chk(32'(img[0]), 32'hA5, "store byte C0");
		chk(32'(img[10]), 32'hFF, "store byte CA");
	endtask

	task automatic t_relock();
		wr(8'h39, 8'h00, 1'b1);
		chk(32'(lck), 32'h1, "not relocked");
		wr(8'hC0, 8'h00, 1'b0);
		rd(8'hC0, 8'hA5);
	endtask

	task automatic t_disable();
		pwd(32'h11223344);
		wr(8'hCA, 8'h00, 1'b1);
		pwd(32'h0);
		chk(32'(lck), 32'h0, "locked while disabled");
		wr(8'hC0, 8'h77, 1'b1);
	endtask

	task automatic t_change();
		refw(32'h55667788);
		wr(8'h3F, 8'h11, 1'b1);
		chk(32'(st), 32'h1, "no store pulse");
		@(negedge ref_clk) chk(32'(img[6]), 32'h88, "new reference not stored");
		wr(8'hCA, 8'hFF, 1'b1);
		chk(32'(lck), 32'h1, "not locked by new reference");
		pwd(32'h55667788);
		wr(8'hCA, 8'h00, 1'b1);
		refw(32'h11223344);
		wr(8'hCA, 8'hFF, 1'b1);
		chk(32'(lck), 32'h1, "old entry still unlocks");
		pwd(32'h11223344);
		chk(32'(lck), 32'h0, "new password refused");
		wr(8'h39, 8'h00, 1'b1);
		chk(32'(lck), 32'h1, "not relocked after change");
	endtask

	task automatic t_zero();
		@(posedge ref_clk) ld <= 1'b1;
		pre[9:6] <= '0;
		pre[10] <= 8'hFF;
		boot();
		chk(32'(lck), 32'h0, "zero reference locked");
		rd(8'hCA, 8'hFF);
	endtask

	initial begin
		resetn = 1'b0;
		req = '0;
		ld = 1'b1;
		pre = '0;
		pre[0] = 8'h5A;
		pre[10:6] = {8'hFF, 8'h11, 8'h22, 8'h33, 8'h44};
		failures = 0;
		samples_checked = 0;
		t_boot();
		t_locked();
		t_unlock();
		t_update();
		t_relock();
		t_disable();
		t_change();
		t_zero();
		stop_test();
	end

	initial begin
		repeat (3000) @(posedge ref_clk);
		failures++;
		stop_test();
	end
endmodule
